// ---- logic/scu_sync_check.sv ----
// Synchronism-check unit with AHB-Lite registers, events and interrupt.
`timescale 1ns/100ps
module scu_sync_check
  import scu_pkg::*;
#(
  parameter int unsigned MS_COUNT = MS_CYCLES
) (
  input  wire logic              clk,            // 200 MHz clock
  input  wire logic              rst_n,          // asynchronous reset
  input  wire logic              hsel,           // AHB select
  input  wire logic [31:0]       haddr,          // AHB address
  input  wire logic [1:0]        htrans,         // AHB transfer type
  input  wire logic              hwrite,         // AHB write
  input  wire logic [2:0]        hsize,          // AHB size, word only
  input  wire logic [31:0]       hwdata,         // AHB write data
  input  wire logic              hready,         // AHB bus ready
  output logic                   hreadyout,      // AHB slave ready
  output logic                   hresp,          // AHB response, OKAY
  output logic [31:0]            hrdata,         // AHB read data
  input  wire logic              meas_valid,     // new measurement set
  input  wire scu_chan_t [7:0]   meas,           // measured channels
  input  wire logic [2:0]        block_in,       // per-stage blocking
  output logic [2:0]             sync_ok_output, // per-stage sync ok
  output logic [2:0]             bypass_out,     // per-stage bypass
  output logic [2:0]             blocked_out,    // per-stage blocked
  output logic                   close_cmd,      // breaker close pulse
  output logic                   evt_valid,      // event pulse
  output scu_evt_t               evt,            // event record
  output logic                   irq             // interrupt level
);

  typedef enum logic [1:0] {S_IDLE, S_ROT, S_CLOSE} scu_state_t;

  // Stages read as not monitored until the first measurement set arrives.
  localparam scu_res_t RES_RST = '{volt: VOLT_NOMON, default: '0};

  scu_ctrl_t          ctrl;
  logic [16:0]        brk_time;
  logic [4:0]         irq_stat;
  logic [4:0]         irq_mask;
  scu_set_t           sets [8];
  scu_set_t           act_set;
  scu_res_t           res [3];
  scu_res_t           next_res [3];
  logic [8:0]         pend;
  logic [31:0]        stamp;
  logic [31:0]        tick;
  logic               wr_ph;
  logic [7:0]         wr_addr;
  logic               rd_ph;
  logic               rd_rdy;
  logic [7:0]         rd_addr;
  logic               accept;
  logic [31:0]        rd_data;
  logic [4:0]         irq_set;
  logic [1:0]         vs;
  scu_state_t         state;
  logic               start_q;
  logic               calc_done;
  logic [39:0]        div_quo;
  logic [39:0]        div_rem;
  logic [39:0]        div_den;
  logic [5:0]         div_cnt;
  logic [39:0]        next_sh;
  logic               next_ge;
  logic [39:0]        next_rem;
  logic [39:0]        next_quo;
  logic [16:0]        rot_time;
  logic [16:0]        close_time;
  logic [16:0]        next_close;
  logic [20:0]        f_abs;
  logic [20:0]        a_abs;
  logic [20:0]        ang_rem;
  logic               approach;
  logic [1:0]         sw_state;
  logic [8:0]         outs;
  logic [8:0]         next_outs;
  logic [8:0]         emit;
  logic [3:0]         emit_src;

  function automatic logic [20:0] abs21(input logic signed [20:0] v);
    return v[20] ? 21'(-v) : 21'(v);
  endfunction

  // Parameter set number from a byte address inside the set window.
  function automatic logic [2:0] set_index(input logic [7:0] a);
    return 3'(a[7:4] - A_SET_LO[7:4]);
  endfunction

  function automatic logic [16:0] sat_time(input logic [39:0] q,
                                           input logic zero_den);
    return (zero_den || q > 40'(TIME_MAX)) ? TIME_MAX : q[16:0];
  endfunction

  function automatic scu_res_t eval_stage(input logic act,
                                          input scu_chan_t a,
                                          input scu_chan_t b,
                                          input scu_set_t s);
    scu_res_t r;
    logic la;
    logic lb;
    logic da;
    logic db;
    r = '0;
    r.active = act;
    la = a.mag > s.live_thr;
    lb = b.mag > s.live_thr;
    da = a.mag < s.dead_thr;
    db = b.mag < s.dead_thr;
    if (!act) r.volt = VOLT_NOMON;
    else if (la && lb) r.volt = VOLT_LL;
    else if (la && db) r.volt = VOLT_LD;
    else if (da && lb) r.volt = VOLT_DL;
    else if (da && db) r.volt = VOLT_DD;
    else r.volt = VOLT_UNDEF;
    r.mag_d = $signed({1'b0, a.mag}) - $signed({1'b0, b.mag});
    if (r.mag_d > $signed(MAG_SPAN)) r.mag_d = $signed(MAG_SPAN);
    if (r.mag_d < -$signed(MAG_SPAN)) r.mag_d = -$signed(MAG_SPAN);
    r.ang_d = 21'(a.ang) - 21'(b.ang);
    r.freq_d = 19'(a.freq) - 19'(b.freq);
    r.mag_ok = act && abs21(21'(r.mag_d)) <= 21'(s.mag_max);
    r.ang_ok = act && abs21(r.ang_d) <= 21'(s.ang_max);
    r.freq_ok = act && abs21(21'(r.freq_d)) <= 21'(s.freq_max);
    r.vcond_ok = act && r.volt <= VOLT_LL && s.vcond[r.volt[1:0]];
    r.bypass = r.vcond_ok && r.volt != VOLT_LL;
    r.ok = r.vcond_ok && r.volt == VOLT_LL && r.mag_ok && r.ang_ok
           && r.freq_ok;
    return r;
  endfunction

  function automatic logic [2:0] cond_code(input scu_res_t r,
                                           input logic blk);
    if (blk) return COND_BLOCKED;
    if (r.ok) return COND_OK;
    if (r.bypass) return COND_BYPASS;
    if (r.vcond_ok) return COND_VCOND;
    if (r.mag_ok) return COND_MAG;
    if (r.ang_ok) return COND_ANG;
    if (r.freq_ok) return COND_FREQ;
    return COND_BLOCKED;
  endfunction

  assign act_set = sets[ctrl.set_sel];

  always_comb begin
    logic one;
    logic both;
    logic [2:0] r1;
    logic [2:0] r2;
    one = ctrl.aux3_sync ^ ctrl.aux4_sync;
    both = ctrl.aux3_sync && ctrl.aux4_sync;
    r1 = ctrl.ref1;
    r2 = {1'b0, ctrl.ref2};
    // single auxiliary channel: stage one only, six references
    next_res[0] = eval_stage(
      (one && r1 != REF_NONE && r1 <= REF_MAX)
      || (both && r1 != REF_NONE && r1 <= REF_LL_MAX),
      (one && ctrl.aux4_sync) ? meas[CH_AUX4] : meas[CH_AUX3],
      meas[3'(r1 - 3'h1)], act_set);
    next_res[1] = eval_stage(both && r2 != REF_NONE && r2 <= REF_LL_MAX,
                             meas[CH_AUX4], meas[3'(r2 - 3'h1)], act_set);
    next_res[2] = eval_stage(both, meas[CH_AUX3], meas[CH_AUX4], act_set);
  end

  always_comb begin
    for (int i = 0; i < 3; i++) begin
      next_outs[i] = next_res[i].ok && !block_in[i];
      next_outs[i + 3] = next_res[i].bypass && !block_in[i];
      next_outs[i + 6] = (next_res[i].ok || next_res[i].bypass)
                         && block_in[i];
    end
  end

  assign outs = {blocked_out, bypass_out, sync_ok_output};

  // RMS set taken on each arrival
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < 3; i++) res[i] <= RES_RST;
      sync_ok_output <= '0;
      bypass_out <= '0;
      blocked_out <= '0;
    end else if (meas_valid) begin
      for (int i = 0; i < 3; i++) res[i] <= next_res[i];
      {blocked_out, bypass_out, sync_ok_output} <= next_outs;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tick <= '0;
      stamp <= '0;
    end else if (tick == MS_COUNT - 1) begin
      tick <= '0;
      stamp <= stamp + 32'h1;
    end else begin
      tick <= tick + 32'h1;
    end
  end

  always_comb begin
    emit = '0;
    emit_src = '0;
    for (int i = 8; i >= 0; i--) begin
      if (pend[i]) begin
        emit = '0;
        emit[i] = 1'b1;
        emit_src = 4'(i);
      end
    end
  end

  // one on or off event per output change, lowest source first
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pend <= '0;
      evt_valid <= 1'b0;
      evt <= '0;
    end else begin
      pend <= (pend & ~emit)
              | (meas_valid ? (next_outs ^ outs) : 9'h000);
      evt_valid <= |pend;
      if (|pend) evt <= '{stamp: stamp, src: emit_src, on: outs[emit_src]};
    end
  end

  // Divider shared by rotation time and closing time.
  assign next_sh = {div_rem[38:0], div_quo[39]};
  assign next_ge = next_sh >= div_den;
  assign next_rem = next_ge ? next_sh - div_den : next_sh;
  assign next_quo = {div_quo[38:0], next_ge};

  assign f_abs = abs21(21'(res[0].freq_d));
  assign a_abs = abs21(res[0].ang_d);
  assign approach = (res[0].freq_d != '0)
                    && (res[0].ang_d[20] != res[0].freq_d[18]);
  assign ang_rem = approach ? a_abs : ANG_FULL - a_abs;
  assign next_close = sat_time(next_quo, f_abs == '0);

  // switching state only with auto close
  always_comb begin
    if (!ctrl.auto_close_enable || res[0].freq_d == '0) sw_state = SW_STILL;
    else if (approach) sw_state = SW_APPR;
    else sw_state = SW_DEPART;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      start_q <= 1'b0;
      state <= S_IDLE;
      div_quo <= '0;
      div_rem <= '0;
      div_den <= '0;
      div_cnt <= '0;
      rot_time <= TIME_MAX;
      close_time <= TIME_MAX;
      calc_done <= 1'b0;
      close_cmd <= 1'b0;
    end else begin
      start_q <= meas_valid;
      calc_done <= 1'b0;
      close_cmd <= 1'b0;
      unique case (state)
        S_IDLE: begin
          if (start_q) begin
            state <= S_ROT;
            div_quo <= ROT_NUM;
            div_rem <= '0;
            div_den <= 40'(f_abs);
            div_cnt <= '0;
          end
        end
        S_ROT: begin
          div_cnt <= div_cnt + 6'h1;
          div_rem <= next_rem;
          div_quo <= next_quo;
          if (div_cnt == DIV_STEPS - 6'h1) begin
            rot_time <= sat_time(next_quo, f_abs == '0);
            state <= S_CLOSE;
            div_quo <= 40'({ang_rem, 2'b00}) + 40'(ang_rem);
            div_rem <= '0;
            div_den <= 40'({f_abs, 3'b000}) + 40'(f_abs);
            div_cnt <= '0;
          end
        end
        S_CLOSE: begin
          div_cnt <= div_cnt + 6'h1;
          div_rem <= next_rem;
          div_quo <= next_quo;
          if (div_cnt == DIV_STEPS - 6'h1) begin
            close_time <= next_close;
            calc_done <= 1'b1;
            state <= S_IDLE;
            close_cmd <= ctrl.auto_close_enable && sync_ok_output[0]
                         && approach && next_close <= brk_time;
          end
        end
      endcase
    end
  end

  // AHB-Lite slave: writes land in the data phase, reads add one wait.
  assign accept = hsel && hready && htrans[1];
  assign hreadyout = !(rd_ph && !rd_rdy);
  assign hresp = 1'b0;
  assign vs = (ctrl.view > 2'h2) ? 2'h2 : ctrl.view;

  always_comb begin
    scu_status_t st;
    scu_set_t s;
    st = '0;
    st.cond = cond_code(res[vs], blocked_out[vs]);
    st.volt = res[vs].volt;
    st.sw = sw_state;
    st.sync_ok = sync_ok_output;
    st.bypass = bypass_out;
    st.blocked = blocked_out;
    s = sets[set_index(rd_addr)];
    rd_data = '0;
    if (rd_addr >= A_SET_LO && rd_addr <= A_SET_HI) begin
      unique case (rd_addr[3:2])
        2'h0: rd_data = {s.dead_thr, s.live_thr};
        2'h1: rd_data = {12'h000, s.vcond, s.mag_max};
        2'h2: rd_data = 32'(s.ang_max);
        2'h3: rd_data = 32'(s.freq_max);
      endcase
    end else begin
      unique case (rd_addr)
        A_CTRL: rd_data = ctrl;
        A_BRK: rd_data = 32'(brk_time);
        A_ISTAT: rd_data = 32'(irq_stat);
        A_IMASK: rd_data = 32'(irq_mask);
        A_STATUS: rd_data = st;
        A_MAGD: rd_data = 32'(res[vs].mag_d);
        A_ANGD: rd_data = 32'(res[vs].ang_d / $signed(ANG_DIV));
        A_FRQD: rd_data = 32'(res[vs].freq_d);
        A_CLOSE: rd_data = 32'(close_time);
        A_ROT: rd_data = 32'(rot_time);
        A_PLACE: rd_data = 32'(res[0].ang_d);
        default: rd_data = '0;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ph <= 1'b0;
      wr_addr <= '0;
      rd_ph <= 1'b0;
      rd_rdy <= 1'b0;
      rd_addr <= '0;
      hrdata <= '0;
    end else begin
      wr_ph <= accept && hwrite;
      if (accept) wr_addr <= haddr[7:0];
      if (accept && !hwrite) begin
        rd_ph <= 1'b1;
        rd_addr <= haddr[7:0];
      end else if (rd_rdy) begin
        rd_ph <= 1'b0;
      end
      rd_rdy <= rd_ph && !rd_rdy;
      if (rd_ph && !rd_rdy) hrdata <= rd_data;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl <= '0;
      brk_time <= BRK_RST;
      irq_mask <= '0;
      for (int i = 0; i < 8; i++) sets[i] <= SET_RST;
    end else if (wr_ph) begin
      if (wr_addr >= A_SET_LO && wr_addr <= A_SET_HI) begin
        unique case (wr_addr[3:2])
          2'h0: {sets[set_index(wr_addr)].dead_thr,
                 sets[set_index(wr_addr)].live_thr} <= hwdata;
          2'h1: {sets[set_index(wr_addr)].vcond,
                 sets[set_index(wr_addr)].mag_max} <= hwdata[19:0];
          2'h2: sets[set_index(wr_addr)].ang_max <= hwdata[19:0];
          2'h3: sets[set_index(wr_addr)].freq_max <= hwdata[17:0];
        endcase
      end else begin
        unique case (wr_addr)
          A_CTRL: begin
            ctrl <= hwdata;
            ctrl.rsvd1 <= 1'b0;
            ctrl.rsvd2 <= '0;
          end
          A_BRK: brk_time <= hwdata[16:0];
          A_IMASK: irq_mask <= hwdata[4:0];
          default: ;
        endcase
      end
    end
  end

  // Sticky status: a new event wins over the clear by read.
  assign irq_set = {|((next_outs[8:6] & ~outs[8:6]) & {3{meas_valid}}),
                    close_cmd,
                    next_outs[2:0] & ~outs[2:0] & {3{meas_valid}}};

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_stat <= '0;
      irq <= 1'b0;
    end else begin
      irq_stat <= (irq_stat & ~((rd_ph && !rd_rdy && rd_addr == A_ISTAT)
                                ? irq_stat : 5'h00)) | irq_set;
      irq <= |(irq_stat & irq_mask);
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  single_aux_stages_a: assert property (
    meas_valid && (ctrl.aux3_sync ^ ctrl.aux4_sync) |=>
    res[1].volt == VOLT_NOMON && res[2].volt == VOLT_NOMON
    && !sync_ok_output[1] && !sync_ok_output[2])
    else $error("inactive stage reported as monitored");
  pair_three_a: assert property (
    meas_valid && ctrl.aux3_sync && ctrl.aux4_sync |=> res[2].active
    && res[2].freq_d == 19'($past(meas[CH_AUX3].freq))
                        - 19'($past(meas[CH_AUX4].freq)))
    else $error("stage three does not compare the aux channels");
  auto_close_a: assert property (
    close_cmd |-> ctrl.auto_close_enable && sync_ok_output[0]
                  && close_time <= brk_time && $past(state) == S_CLOSE)
    else $error("close command without synchronized stage one");
  diff_gate_a: assert property (
    sync_ok_output[0] |-> res[0].mag_ok && res[0].ang_ok && res[0].freq_ok)
    else $error("sync ok with a difference out of limit");
  event_drain_a: assert property (
    $rose(sync_ok_output[0]) |-> ##1 evt_valid && evt.src == 4'h0 && evt.on)
    else $error("sync ok rise not logged");
  vcond_need_a: assert property (
    bypass_out[0] |-> res[0].vcond_ok && res[0].volt != VOLT_LL)
    else $error("bypass without allowed voltage state");
  no_mode_volt_a: assert property (
    meas_valid && !ctrl.aux3_sync && !ctrl.aux4_sync |=>
    res[0].volt == VOLT_NOMON && !sync_ok_output[0])
    else $error("stage one monitored with no aux channel");
  calc_time_a: assert property (
    start_q && state == S_IDLE |-> ##81 calc_done)
    else $error("time estimates not refreshed in 81 cycles");
  time_cap_a: assert property (
    close_time <= TIME_MAX && rot_time <= TIME_MAX)
    else $error("time estimate above 360 s");
  irq_sync_a: assert property (
    $rose(sync_ok_output[0]) && irq_mask[0] |=> irq)
    else $error("unmasked sync ok did not raise interrupt");

  sync_seen_c: cover property ($rose(sync_ok_output[0]));
  bypass_seen_c: cover property ($rose(bypass_out[0]));
  close_seen_c: cover property (close_cmd);
  blocked_seen_c: cover property ($rose(blocked_out[2]));

endmodule

// ---- logic/scu_pkg.sv ----
// Package of types, register map and constants for the synchronism-check unit.
// Contract
// - One auxiliary channel in sync mode: only stage one, six references.
// - Both channels: stage one aux3, stage two aux4, stage three aux3-aux4.
// - Auto close enabled: stage one issues close command once synchronized, approaching, and closing time within breaker time.
// - Sync only when magnitude, frequency, angle differences are in limits.
// - Sync-ok, bypass, blocked changes log time-stamped events, 1 ms stamp.
// - Eight parameter sets, active set chosen by one common selector.
// - Each side classified live or dead against live and dead thresholds.
// - Selected live/dead combination is also required before synchronized.
// - Inputs are RMS voltage measurements arriving on a 5 ms base.
// - Stage condition code 0 blocked to 6 frequency ok.
// - Voltage state code 0 dead-dead to 5 not monitored.
// - Magnitude difference in 0.01 percent, clamped to plus/minus 120.
// - Angle difference reported in 0.01 degree steps.
// - Frequency difference reported in 0.001 hertz steps.
// - Switch state still, departing, approaching; only with auto close.
// - Estimated time to closing, 0 to 360 s in 0.005 s steps.
// - Time of one full relative rotation in 0.005 s steps.
// - Present relative angle in 0.001 degree steps.
package scu_pkg;

  localparam int unsigned CLK_HZ     = 200_000_000;
  localparam int unsigned STAMP_MS   = 1;
  localparam int unsigned MS_CYCLES  = CLK_HZ / 1000 * STAMP_MS;

  // Channel indices: 0..2 line voltages ab/bc/ca, 3..5 phase a/b/c, 6..7 aux.
  localparam logic [2:0] CH_AUX3   = 3'h6;
  localparam logic [2:0] CH_AUX4   = 3'h7;
  localparam logic [2:0] REF_NONE  = 3'h0;
  localparam logic [2:0] REF_LL_MAX = 3'h3;
  localparam logic [2:0] REF_MAX   = 3'h6;

  typedef struct packed {
    logic        [15:0] mag;   // RMS in 0.01 percent of nominal
    logic signed [19:0] ang;   // 0.001 deg
    logic signed [17:0] freq;  // 0.001 Hz
  } scu_chan_t;

  typedef struct packed {
    logic [15:0] live_thr;
    logic [15:0] dead_thr;
    logic [15:0] mag_max;
    logic [19:0] ang_max;
    logic [17:0] freq_max;
    logic [3:0]  vcond;        // allowed voltage states, bit index = state code
  } scu_set_t;

  typedef struct packed {
    logic               active;
    logic        [2:0]  volt;
    logic signed [16:0] mag_d;
    logic signed [20:0] ang_d;
    logic signed [18:0] freq_d;
    logic               vcond_ok;
    logic               mag_ok;
    logic               ang_ok;
    logic               freq_ok;
    logic               bypass;
    logic               ok;
  } scu_res_t;

  typedef struct packed {
    logic [31:0] stamp;
    logic [3:0]  src;
    logic        on;
  } scu_evt_t;

  typedef struct packed {
    logic [17:0] rsvd2;
    logic [1:0]  ref2;
    logic        rsvd1;
    logic [2:0]  ref1;
    logic [1:0]  view;
    logic [2:0]  set_sel;
    logic        auto_close_enable;
    logic        aux4_sync;
    logic        aux3_sync;
  } scu_ctrl_t;

  typedef struct packed {
    logic [4:0] rsvd5;
    logic [2:0] blocked;
    logic       rsvd4;
    logic [2:0] bypass;
    logic       rsvd3;
    logic [2:0] sync_ok;
    logic [5:0] rsvd2;
    logic [1:0] sw;
    logic       rsvd1;
    logic [2:0] volt;
    logic       rsvd0;
    logic [2:0] cond;
  } scu_status_t;

  localparam logic [2:0] COND_BLOCKED = 3'h0;
  localparam logic [2:0] COND_OK      = 3'h1;
  localparam logic [2:0] COND_BYPASS  = 3'h2;
  localparam logic [2:0] COND_VCOND   = 3'h3;
  localparam logic [2:0] COND_MAG     = 3'h4;
  localparam logic [2:0] COND_ANG     = 3'h5;
  localparam logic [2:0] COND_FREQ    = 3'h6;

  localparam logic [2:0] VOLT_DD    = 3'h0;
  localparam logic [2:0] VOLT_LD    = 3'h1;
  localparam logic [2:0] VOLT_DL    = 3'h2;
  localparam logic [2:0] VOLT_LL    = 3'h3;
  localparam logic [2:0] VOLT_UNDEF = 3'h4;
  localparam logic [2:0] VOLT_NOMON = 3'h5;

  localparam logic [1:0] SW_STILL  = 2'h0;
  localparam logic [1:0] SW_DEPART = 2'h1;
  localparam logic [1:0] SW_APPR   = 2'h2;

  localparam logic [7:0] A_CTRL   = 8'h00;
  localparam logic [7:0] A_BRK    = 8'h04;
  localparam logic [7:0] A_ISTAT  = 8'h08;
  localparam logic [7:0] A_IMASK  = 8'h0c;
  localparam logic [7:0] A_STATUS = 8'h10;
  localparam logic [7:0] A_MAGD   = 8'h14;
  localparam logic [7:0] A_ANGD   = 8'h18;
  localparam logic [7:0] A_FRQD   = 8'h1c;
  localparam logic [7:0] A_CLOSE  = 8'h20;
  localparam logic [7:0] A_ROT    = 8'h24;
  localparam logic [7:0] A_PLACE  = 8'h28;
  localparam logic [7:0] A_SET_LO = 8'h40;
  localparam logic [7:0] A_SET_HI = 8'hbc;

  localparam logic [16:0] BRK_RST    = 17'h0000a;
  localparam logic [16:0] TIME_MAX   = 17'h11940;
  localparam logic [16:0] MAG_SPAN   = 17'h02ee0;
  localparam logic [20:0] ANG_FULL   = 21'h057e40;
  localparam logic [39:0] ROT_NUM    = 40'h0000030d40;
  localparam logic [5:0]  DIV_STEPS  = 6'h28;
  localparam logic [20:0] ANG_DIV    = 21'h00000a;
  localparam logic [3:0]  N_EVT      = 4'h9;

  localparam scu_set_t SET_RST = '{live_thr: 16'h1f40, dead_thr: 16'h0fa0,
                                   mag_max: 16'h01f4, ang_max: 20'h02710,
                                   freq_max: 18'h000c8, vcond: 4'h8};

endpackage

// ---- verif/scu_meas_src.sv ----
// Measurement front end model that feeds RMS channel sets to the unit.
`timescale 1ns/100ps
module scu_meas_src import scu_pkg::*; (
  input  wire logic      clk,        // system clock
  output logic           meas_valid, // new set pulse
  output scu_chan_t [7:0] meas       // channel values
);
  initial begin
    meas_valid = 1'b0;
    meas = '0;
  end
  task automatic send(input logic [15:0] ref_mag, input logic [15:0] aux_mag,
                      input logic [19:0] aux_ang = 20'h00000,
                      input logic [17:0] aux_freq = 18'h00000);
    scu_chan_t [7:0] m;
    m = '0;
    m[3].mag = ref_mag;
    m[6].mag = aux_mag;
    m[6].ang = aux_ang;
    m[6].freq = aux_freq;
    @(posedge clk);
    meas <= m;
    meas_valid <= 1'b1;
    @(posedge clk);
    meas_valid <= 1'b0;
    repeat (100) @(posedge clk);
  endtask
endmodule

// ---- verif/synchronism_check_unit_test.sv ----
// Self-checking bench for the synchronism-check unit.
`timescale 1ns/100ps
module synchronism_check_unit_test import scu_pkg::*;;
  logic            clk, rst_n, hsel, hwrite, hreadyout, hresp, irq;
  logic            evt_valid, meas_valid, close_cmd, last_on;
  logic [1:0]      htrans;
  logic [2:0]      block_in, sync_ok_output, bypass_out, blocked_out;
  logic [3:0]      last_src;
  logic [31:0]     haddr, hwdata, hrdata, rd;
  scu_chan_t [7:0] meas;
  scu_evt_t        evt;
  int              num_errors, total_checks;
  int              close_cnt = 0;
  scu_sync_check #(.MS_COUNT(10)) dut (.clk(clk), .rst_n(rst_n),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .meas_valid(meas_valid), .meas(meas), .block_in(block_in),
    .sync_ok_output(sync_ok_output), .bypass_out(bypass_out),
    .blocked_out(blocked_out), .close_cmd(close_cmd),
    .evt_valid(evt_valid), .evt(evt), .irq(irq));
  scu_meas_src src (.clk(clk), .meas_valid(meas_valid), .meas(meas));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk) if (evt_valid === 1'b1) begin
    last_src <= evt.src;
    last_on <= evt.on;
  end
  always @(posedge clk) if (close_cmd === 1'b1) close_cnt <= close_cnt + 1;
  task automatic check(input string name, input logic [31:0] exp, got);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic ahb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    @(posedge clk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'b1);
    q = hrdata;
    hsel <= 1'b0;
  endtask
  task tally_and_finish;
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task t_reset;
    ahb(1'b0, A_CTRL, 32'h0, rd);
    check("ctrl", 32'h0, rd);
    ahb(1'b0, A_BRK, 32'h0, rd);
    check("brk", 32'h0000000a, rd);
    ahb(1'b0, A_STATUS, 32'h0, rd);
    check("status", 32'h00000050, rd);
    ahb(1'b0, 8'h30, 32'h0, rd);
    check("unmapped", 32'h0, rd);
  endtask
  task t_sync_ok;
    ahb(1'b1, A_IMASK, 32'h1, rd);
    ahb(1'b1, A_CTRL, 32'h00000401, rd);
    src.send(16'h2710, 16'h2710);
    check("sync_ok", 32'h1, sync_ok_output);
    check("irq", 32'h1, irq);
    check("event", 32'h01, {last_src, last_on});
    ahb(1'b0, A_STATUS, 32'h0, rd);
    check("status", 32'h00010031, rd);
    ahb(1'b0, A_ISTAT, 32'h0, rd);
    check("istat", 32'h1, rd);
    repeat (2) @(posedge clk);
    check("irq clr", 32'h0, irq);
  endtask
  task t_mag;
    src.send(16'h2000, 16'h2710);
    check("sync_ok", 32'h0, sync_ok_output);
    check("event", 32'h00, {last_src, last_on});
    ahb(1'b0, A_STATUS, 32'h0, rd);
    check("status", 32'h00000033, rd);
  endtask
  task t_block;
    block_in <= 3'h1;
    src.send(16'h2710, 16'h2710);
    check("blocked", 32'h1, blocked_out);
    check("sync_ok", 32'h0, sync_ok_output);
    check("event", 32'h0d, {last_src, last_on});
    ahb(1'b0, A_STATUS, 32'h0, rd);
    check("status", 32'h01000030, rd);
    block_in <= 3'h0;
  endtask
  task t_close;
    ahb(1'b1, A_CTRL, 32'h00000405, rd);
    src.send(16'h2710, 16'h2710, 20'hff8f8, 18'h00064);
    check("close_cmd", 32'h1, close_cnt);
    ahb(1'b0, A_CLOSE, 32'h0, rd);
    check("close time", 32'h0000000a, rd);
    ahb(1'b0, A_ROT, 32'h0, rd);
    check("rot time", 32'h000007d0, rd);
    ahb(1'b0, A_PLACE, 32'h0, rd);
    check("place", 32'hfffff8f8, rd);
    ahb(1'b0, A_ANGD, 32'h0, rd);
    check("ang diff", 32'hffffff4c, rd);
    ahb(1'b0, A_FRQD, 32'h0, rd);
    check("freq diff", 32'h00000064, rd);
    ahb(1'b0, A_STATUS, 32'h0, rd);
    check("status", 32'h00010231, rd);
    ahb(1'b0, A_ISTAT, 32'h0, rd);
    check("istat", 32'h00000019, rd);
  endtask
  task t_bypass;
    ahb(1'b1, A_SET_LO + 8'h04, 32'h000a01f4, rd);
    ahb(1'b0, A_SET_LO + 8'h04, 32'h0, rd);
    check("set vcond", 32'h000a01f4, rd);
    src.send(16'h0100, 16'h2710);
    check("bypass", 32'h1, bypass_out);
    ahb(1'b0, A_STATUS, 32'h0, rd);
    check("status", 32'h00100012, rd);
    ahb(1'b0, A_MAGD, 32'h0, rd);
    check("mag diff", 32'h00002610, rd);
    check("hresp", 32'h0, hresp);
    ahb(1'b1, A_CTRL, 32'h00000183, rd);
    src.send(16'h0000, 16'h2710);
    check("bypass", 32'h5, bypass_out);
    ahb(1'b0, A_STATUS, 32'h0, rd);
    check("status", 32'h00500012, rd);
  endtask
  initial begin
    rst_n = 1'b0;
    hsel = 1'b0;
    haddr = '0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hwdata = '0;
    block_in = 3'h0;
    num_errors = 0;
    total_checks = 0;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    t_reset;
    t_sync_ok;
    t_mag;
    t_block;
    t_close;
    t_bypass;
    tally_and_finish;
  end
  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    tally_and_finish;
  end
endmodule
